// ===== ksi_pkg.sv
// Shared constants, types and helpers for the keypad scan input block
`default_nettype none
package ksi_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL     = 8'h00;
  localparam logic [7:0] OFF_HEX_LO   = 8'h04;
  localparam logic [7:0] OFF_HEX_HI   = 8'h08;
  localparam logic [7:0] OFF_HEX_KEYS = 8'h0c;
  localparam logic [7:0] OFF_TEN_LO   = 8'h10;
  localparam logic [7:0] OFF_TEN_HI   = 8'h14;
  localparam logic [7:0] OFF_TEN_KEYS = 8'h18;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h1c;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h20;
  localparam logic [7:0] OFF_BASE     = 8'h24;
  localparam logic [7:0] OFF_FLAGS    = 8'h28;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions and reset values
  localparam int CTRL_HEX_EN    = 0;
  localparam int CTRL_TEN_EN    = 1;
  localparam int IRQ_HEX_KEY    = 0;
  localparam int IRQ_TEN_KEY    = 1;
  localparam int IRQ_ERROR      = 2;
  localparam logic [1:0]  CTRL_RESET  = 2'h3;
  localparam logic [2:0]  MASK_RESET  = 3'h0;
  localparam logic [31:0] BASE_RESET  = 32'h0000_0000;
  localparam logic [15:0] AREA_LAST_DEFAULT = 16'h1fff;
  localparam int          SCAN_DIV_DEFAULT  = 8;
  localparam logic [15:0] HEX_GROUP_SPAN    = 16'h0002;
  localparam logic [15:0] TEN_GROUP_SPAN    = 16'h0001;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [1:0] {
    HS_IDLE = 2'b00,
    HS_SCAN = 2'b01,
    HS_HELD = 2'b11
  } hex_state_type;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } apb_req_type;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } apb_rsp_type;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic bcd_ok(input logic [15:0] v);
    bcd_ok = (v[3:0] < 4'ha) && (v[7:4] < 4'ha) && (v[11:8] < 4'ha) && (v[15:12] < 4'ha);
  endfunction : bcd_ok

  function automatic logic [15:0] bcd_to_bin(input logic [15:0] v);
    bcd_to_bin = 16'(v[15:12] * 1000) + 16'(v[11:8] * 100) + 16'(v[7:4] * 10)
               + 16'(v[3:0]);
  endfunction : bcd_to_bin

  function automatic logic [3:0] low_index(input logic [15:0] v);
    logic [3:0] idx;
    idx = 4'h0;
    for (int i = 15; i >= 0; i--)
    begin
      if (v[i])
      begin
        idx = 4'(i);
      end
    end
    low_index = idx;
  endfunction : low_index

endpackage : ksi_pkg
`default_nettype wire

// ===== ksi_sync.sv
// Two flip-flop synchroniser for a bus of asynchronous pin levels
`timescale 1ns/1ps
`default_nettype none
module ksi_sync #(
  parameter int W = 4
) (
  // Clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // Levels
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);

  logic [W-1:0] meta_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_q <= '0;
      q      <= '0;
    end
    else
    begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule : ksi_sync
`default_nettype wire

// ===== ksi_keypad.sv
// Hex matrix scanner and ten-key reader with APB registers and interrupt
//
// The implementer's own choices: the address map and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Each function idles unless enabled; scans and updates only while enabled.
// - Hex value is eight digits across two 16-bit words, low word least significant.
// - Accepted hex key shifts value left one digit, key enters lowest digit.
// - While hex key k held, key word bit k and drive bit 4 are set.
// - While one hex key is held, all other hex keys are ignored.
// - A hex key press resolves within five scan cycles.
// - Key found by driving matrix lines and sampling return lines.
// - Five drive outputs and four return inputs; output 4 flags key down.
// - Hex scanning starts from the first cycle after reset.
// - Busy flag is high in every cycle after one in which the hex function runs.
// - Error and no operation when the result group crosses the area end.
// - Error when result pointer is not BCD or lies beyond the area.
// - Accepted ten-key shifts BCD value left, digit enters lowest place.
// - While ten-key k held, status bit k is set; only ten bits used.
// - While one ten-key is held, other keys are refused.
// - Ten direct inputs, key n wired to input n.
module ksi_keypad #(
  parameter int          SCAN_DIV  = ksi_pkg::SCAN_DIV_DEFAULT,
  parameter logic [15:0] AREA_LAST = ksi_pkg::AREA_LAST_DEFAULT
) (
  // Clock and reset
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  // APB slave
  input  wire ksi_pkg::apb_req_type apb_req,
  output var  ksi_pkg::apb_rsp_type apb_rsp,
  // Hex matrix pins
  input  wire logic [3:0]           key_input_word,
  output var  logic [4:0]           matrix_drive_word,
  // Ten-key pins
  input  wire logic [9:0]           ten_key_input,
  // Status
  output var  logic                 hex_scan_busy_flag,
  output var  logic                 error_flag,
  output var  logic                 irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [3:0] row_s;
  logic [9:0] ten_s;

  ksi_sync #(.W(4)) u_row_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       (key_input_word),
    .q       (row_s)
  );

  ksi_sync #(.W(10)) u_ten_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       (ten_key_input),
    .q       (ten_s)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Scan-cycle divider
  // one scan cycle per tick; a press resolves within five ticks
  logic [7:0] div_q;
  wire        scan_tick = (div_q == 8'(SCAN_DIV - 1));

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      div_q <= 8'h00;
    else
      div_q <= scan_tick ? 8'h00 : div_q + 8'h01;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers and bus decode
  logic [1:0]  ctrl_q;
  logic [31:0] base_q;
  logic [2:0]  stat_q;
  logic [2:0]  mask_q;
  logic [31:0] hex_val_q;
  logic [31:0] ten_val_q;
  logic [15:0] hex_keys_q;
  logic [9:0]  ten_keys_q;
  logic [31:0] prdata_q;

  wire setup_rd = apb_req.psel && !apb_req.penable && !apb_req.pwrite;
  wire wr_acc   = apb_req.psel && apb_req.penable && apb_req.pwrite;
  wire [7:0] adr = apb_req.paddr;
  wire hit = (adr[1:0] == 2'b00) && (adr <= ksi_pkg::OFF_FLAGS);
  wire wr_ctrl = wr_acc && (adr == ksi_pkg::OFF_CTRL);
  wire wr_stat = wr_acc && (adr == ksi_pkg::OFF_IRQ_STAT);
  wire wr_mask = wr_acc && (adr == ksi_pkg::OFF_IRQ_MASK);
  wire wr_base = wr_acc && (adr == ksi_pkg::OFF_BASE);

  ////////////////////////////////////////////////////////////////////////////
  // Result-area checks
  wire [15:0] hex_base = base_q[15:0];
  wire [15:0] ten_base = base_q[31:16];
  wire [15:0] area_bin = ksi_pkg::bcd_to_bin(AREA_LAST);
  // pointer not BCD or past the area
  // whole group must fit inside the area
  wire hex_err = !ksi_pkg::bcd_ok(hex_base) ||
                 (ksi_pkg::bcd_to_bin(hex_base) > area_bin - ksi_pkg::HEX_GROUP_SPAN);
  wire ten_err = !ksi_pkg::bcd_ok(ten_base) ||
                 (ksi_pkg::bcd_to_bin(ten_base) > area_bin - ksi_pkg::TEN_GROUP_SPAN);
  // each function runs only while enabled and its area is good
  wire hex_run = ctrl_q[ksi_pkg::CTRL_HEX_EN] && !hex_err;
  wire ten_run = ctrl_q[ksi_pkg::CTRL_TEN_EN] && !ten_err;
  wire err_now = (ctrl_q[ksi_pkg::CTRL_HEX_EN] && hex_err) ||
                 (ctrl_q[ksi_pkg::CTRL_TEN_EN] && ten_err);

  ////////////////////////////////////////////////////////////////////////////
  // Hex matrix scanner
  ksi_pkg::hex_state_type hs_q;
  ksi_pkg::hex_state_type hs_d;
  logic [1:0] col_q;
  logic [1:0] row_held_q;

  wire [3:0] row_idx   = ksi_pkg::low_index({12'h000, row_s});
  wire [3:0] hex_key   = {row_idx[1:0], col_q};
  wire       row_any   = |row_s;
  wire       held_gone = !row_s[row_held_q];
  // new keys only from SCAN, never while one is held
  wire       hex_accept = hex_run && (hs_q == ksi_pkg::HS_SCAN) && scan_tick && row_any;
  wire       hex_release = (hs_q == ksi_pkg::HS_HELD) && scan_tick && held_gone;

  always_comb
  begin
    hs_d = hs_q;
    case (hs_q)
      ksi_pkg::HS_IDLE: hs_d = hex_run ? ksi_pkg::HS_SCAN : ksi_pkg::HS_IDLE;
      ksi_pkg::HS_SCAN: hs_d = !hex_run ? ksi_pkg::HS_IDLE :
                               hex_accept ? ksi_pkg::HS_HELD : ksi_pkg::HS_SCAN;
      ksi_pkg::HS_HELD: hs_d = !hex_run ? ksi_pkg::HS_IDLE :
                               hex_release ? ksi_pkg::HS_SCAN : ksi_pkg::HS_HELD;
      default:          hs_d = ksi_pkg::HS_IDLE;
    endcase
  end

  // reset leaves the scanner enabled so it starts at once
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      hs_q <= ksi_pkg::HS_IDLE;
    else
      hs_q <= hs_d;
  end

  // fixed rotating column, parked while a key is held
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      col_q <= 2'h0;
    else if (hs_q == ksi_pkg::HS_SCAN && scan_tick && !row_any)
      col_q <= col_q + 2'h1;
  end

  // shift one digit left, key into lowest digit
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      hex_val_q  <= 32'h0000_0000;
      row_held_q <= 2'h0;
    end
    else if (hex_accept)
    begin
      hex_val_q  <= {hex_val_q[27:0], hex_key};
      row_held_q <= row_idx[1:0];
    end
  end

  // key word bit follows the held key
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      hex_keys_q <= 16'h0000;
    else if (hex_accept)
      hex_keys_q <= 16'h0001 << hex_key;
    else if (hex_release || hs_d == ksi_pkg::HS_IDLE)
      hex_keys_q <= 16'h0000;
  end

  // one-hot drive on 0..3, key-down on 4; quiet when idle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      matrix_drive_word <= 5'h00;
    else if (hs_d == ksi_pkg::HS_IDLE)
      matrix_drive_word <= 5'h00;
    else
      matrix_drive_word <= {hs_d == ksi_pkg::HS_HELD,
                            4'h1 << (hex_accept || hs_q == ksi_pkg::HS_HELD ||
                                     !(scan_tick && hs_q == ksi_pkg::HS_SCAN) ?
                                     col_q : col_q + 2'h1)};
  end

  assign hex_scan_busy_flag = (hs_q != ksi_pkg::HS_IDLE);

  ////////////////////////////////////////////////////////////////////////////
  // Ten-key reader
  logic       ten_held_q;
  logic [3:0] ten_idx_q;

  wire [3:0] ten_first   = ksi_pkg::low_index({6'h00, ten_s});
  // a new key only while nothing is held
  wire       ten_accept  = ten_run && scan_tick && !ten_held_q && (|ten_s);
  wire       ten_release = ten_held_q && scan_tick && !ten_s[ten_idx_q];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ten_val_q  <= 32'h0000_0000;
      ten_idx_q  <= 4'h0;
      ten_held_q <= 1'b0;
    end
    else if (!ten_run)
      ten_held_q <= 1'b0;
    else if (ten_accept)
    begin
      ten_val_q  <= {ten_val_q[27:0], ten_first};
      ten_idx_q  <= ten_first;
      ten_held_q <= 1'b1;
    end
    else if (ten_release)
      ten_held_q <= 1'b0;
  end

  // status bit of the held digit only
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ten_keys_q <= 10'h000;
    else if (ten_accept)
      ten_keys_q <= 10'h001 << ten_first;
    else if (ten_release || !ten_run)
      ten_keys_q <= 10'h000;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control, base and interrupt registers
  logic err_q;
  wire  err_rise = err_now && !err_q;
  wire [2:0] ev = {err_rise, ten_accept, hex_accept};

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q <= ksi_pkg::CTRL_RESET;
      mask_q <= ksi_pkg::MASK_RESET;
      base_q <= ksi_pkg::BASE_RESET;
      err_q  <= 1'b0;
    end
    else
    begin
      err_q <= err_now;
      if (wr_ctrl)
        ctrl_q <= apb_req.pwdata[1:0];
      if (wr_mask)
        mask_q <= apb_req.pwdata[2:0];
      if (wr_base)
        base_q <= apb_req.pwdata;
    end
  end

  // Set wins over a write-one clear in the same cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      stat_q <= 3'h0;
    else
      stat_q <= (stat_q & ~(wr_stat ? apb_req.pwdata[2:0] : 3'h0)) | ev;
  end

  assign irq        = |(stat_q & mask_q);
  assign error_flag = err_q;

  ////////////////////////////////////////////////////////////////////////////
  // Read path: captured in setup so the access phase sees a flop
  // low word holds the least significant four digits
  wire [31:0] rd_mux =
      (adr == ksi_pkg::OFF_CTRL)     ? {30'h0, ctrl_q} :
      (adr == ksi_pkg::OFF_HEX_LO)   ? {16'h0, hex_val_q[15:0]} :
      (adr == ksi_pkg::OFF_HEX_HI)   ? {16'h0, hex_val_q[31:16]} :
      (adr == ksi_pkg::OFF_HEX_KEYS) ? {16'h0, hex_keys_q} :
      (adr == ksi_pkg::OFF_TEN_LO)   ? {16'h0, ten_val_q[15:0]} :
      (adr == ksi_pkg::OFF_TEN_HI)   ? {16'h0, ten_val_q[31:16]} :
      (adr == ksi_pkg::OFF_TEN_KEYS) ? {22'h0, ten_keys_q} :
      (adr == ksi_pkg::OFF_IRQ_STAT) ? {29'h0, stat_q} :
      (adr == ksi_pkg::OFF_IRQ_MASK) ? {29'h0, mask_q} :
      (adr == ksi_pkg::OFF_BASE)     ? base_q :
      (adr == ksi_pkg::OFF_FLAGS)    ? {30'h0, err_q, hex_scan_busy_flag} :
                                       32'h0000_0000;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_q <= 32'h0000_0000;
    else if (setup_rd)
      prdata_q <= rd_mux;
  end

  // One driver for the whole response struct
  assign apb_rsp = '{pready:  1'b1,
                     pslverr: apb_req.psel && apb_req.penable && !hit,
                     prdata:  prdata_q};

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_idle_quiet: assert property (!hex_run |=> matrix_drive_word == 5'h00)
    else $error("drive active while hex function disabled");
  chk_hex_shift: assert property (hex_accept |=> hex_val_q ==
      {$past(hex_val_q[27:0]), $past(hex_key)})
    else $error("hex value did not shift in key");
  chk_key_bit: assert property (hs_q == ksi_pkg::HS_HELD && $past(hs_q) == ksi_pkg::HS_HELD
      |-> hex_keys_q[hex_val_q[3:0]] && $onehot(hex_keys_q) && matrix_drive_word[4])
    else $error("held key not shown");
  chk_hex_lock: assert property (hs_q == ksi_pkg::HS_HELD && !hex_release
      |=> $stable(hex_val_q))
    else $error("hex value changed while key held");
  chk_one_drive: assert property ($onehot0(matrix_drive_word[3:0]))
    else $error("more than one drive line active");
  chk_busy_state: assert property (hex_scan_busy_flag |-> $past(hex_run))
    else $error("busy without hex function running");
  chk_err_halt: assert property (hex_err |=> hs_q == ksi_pkg::HS_IDLE && !hex_accept)
    else $error("hex function ran with bad result area");
  chk_ten_shift: assert property (ten_accept |=> ten_val_q[31:4] ==
      $past(ten_val_q[27:0]) && ten_val_q[3:0] < 4'ha)
    else $error("ten-key value did not shift");
  chk_ten_bit: assert property (ten_accept |=> ten_keys_q == (10'h001 << ten_val_q[3:0]))
    else $error("ten-key status bit wrong");
  chk_ten_once: assert property (ten_held_q && !ten_release |=> !ten_accept[*2])
    else $error("second ten-key accepted while one held");
  chk_hex_once: assert property (hex_accept |=> !hex_accept[*2])
    else $error("hex key accepted twice");

  cov_hex_press: cover property (hex_accept ##[1:200] hex_release);
  cov_ten_press: cover property (ten_accept ##[1:200] ten_release);
  cov_err_irq:   cover property (err_rise ##1 irq);

endmodule : ksi_keypad
`default_nettype wire

// ===== ksi_matrix_model.sv
// Behavioural 4 x 4 key switch matrix standing on the hex scanner pins
`timescale 1ns/1ps
`default_nettype none
module ksi_matrix_model (
  // Drive lines from the scanner
  input  wire logic [4:0] matrix_drive_word,
  // Keys closed by the bench, code is row then column
  input  wire logic [3:0] key_a,
  input  wire logic       press_a,
  input  wire logic [3:0] key_b,
  input  wire logic       press_b,
  // Return lines, pulled down while no closed key joins them
  output var  logic [3:0] key_input_word
);
  ////////////////////////////////////////////////////////////////////////////
  // one key joins one drive to one return
  always_comb
  begin
    key_input_word = 4'h0;
    if (press_a && matrix_drive_word[key_a[1:0]])
      key_input_word[key_a[3:2]] = 1'b1;
    if (press_b && matrix_drive_word[key_b[1:0]])
      key_input_word[key_b[3:2]] = 1'b1;
  end
endmodule : ksi_matrix_model
`default_nettype wire

// ===== ksi_keypad_tb.sv
// Self-checking bench for the keypad scanner over APB
`timescale 1ns/1ps
`default_nettype none
module ksi_keypad_tb;
  localparam int DIV     = 4;
  localparam int LAT_MAX = 13 * DIV + 3;
  logic                 pclk;
  logic                 presetn;
  ksi_pkg::apb_req_type apb_req;
  ksi_pkg::apb_rsp_type apb_rsp;
  logic [3:0]           key_input_word;
  logic [4:0]           matrix_drive_word;
  logic [9:0]           ten_key_input;
  logic                 hex_scan_busy_flag;
  logic                 error_flag;
  logic                 irq;
  logic [3:0]           key_a;
  logic [3:0]           key_b;
  logic                 press_a;
  logic                 press_b;
  logic [31:0]          rd;
  logic [31:0]          hexv;
  logic [31:0]          tenv;
  logic [3:0]           prev;
  logic                 err;
  int                   n;
  int                   failures;
  int                   comparisons;

  ksi_keypad #(.SCAN_DIV(DIV), .AREA_LAST(16'h0100)) uut (
    .pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .key_input_word(key_input_word), .matrix_drive_word(matrix_drive_word),
    .ten_key_input(ten_key_input), .hex_scan_busy_flag(hex_scan_busy_flag),
    .error_flag(error_flag), .irq(irq));
  ksi_matrix_model keys (
    .matrix_drive_word(matrix_drive_word), .key_a(key_a), .press_a(press_a),
    .key_b(key_b), .press_b(press_b), .key_input_word(key_input_word));

  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("failures=%0d comparisons=%0d", failures, comparisons);
    if (failures == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : final_report

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      $display("FAIL %s expected %h seen %h", name, exp, got);
      failures++;
    end
  endtask : check

  task automatic timeout(input string name);
    $display("FAIL %s expected done seen timeout", name);
    failures++;
    final_report();
  endtask : timeout

  // Setup cycle, then access held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int i;
    @(posedge pclk);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
    @(posedge pclk);
    apb_req.penable <= 1'b1;
    for (i = 0; i < 20; i++)
    begin
      @(posedge pclk);
      if (apb_rsp.pready === 1'b1)
        break;
    end
    rd = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
    if (i == 20)
      timeout("apb pready");
  endtask : apb

  task automatic rdchk(input string name, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(name, exp, rd);
  endtask : rdchk

  task automatic wait_held(input logic want);
    for (n = 0; n < 200; n++)
    begin
      @(posedge pclk);
      if (matrix_drive_word[4] === want)
        break;
    end
    if (n == 200)
      timeout("key down line");
  endtask : wait_held

  task automatic wait_ten(input logic [31:0] m, input logic want);
    int i;
    for (i = 0; i < 100; i++)
    begin
      apb(1'b0, ksi_pkg::OFF_TEN_KEYS, 32'h0);
      if (((rd & m) !== 32'h0) == want)
        break;
    end
    if (i == 100)
      timeout("ten key status");
  endtask : wait_ten

  task automatic hex_key(input logic [3:0] k);
    key_a <= k;
    press_a <= 1'b1;
    wait_held(1'b1);
    check("hex latency", 32'h1, 32'(n <= LAT_MAX));
    hexv = {hexv[27:0], k};
    repeat (10 * DIV) @(posedge pclk);
    rdchk("hex key word", ksi_pkg::OFF_HEX_KEYS, 32'h1 << k);
    rdchk("hex low", ksi_pkg::OFF_HEX_LO, {16'h0, hexv[15:0]});
    rdchk("hex high", ksi_pkg::OFF_HEX_HI, {16'h0, hexv[31:16]});
    press_a <= 1'b0;
    wait_held(1'b0);
  endtask : hex_key

  task automatic ten_key(input int k);
    ten_key_input <= 10'h1 << k;
    wait_ten(32'h1 << k, 1'b1);
    tenv = {tenv[27:0], 4'(k)};
    repeat (10 * DIV) @(posedge pclk);
    rdchk("ten low", ksi_pkg::OFF_TEN_LO, {16'h0, tenv[15:0]});
    rdchk("ten high", ksi_pkg::OFF_TEN_HI, {16'h0, tenv[31:16]});
    ten_key_input <= 10'h0;
    wait_ten(32'h3ff, 1'b0);
  endtask : ten_key

  initial
  begin
    repeat (100000) @(posedge pclk);
    timeout("run");
  end

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    failures = 0;
    comparisons = 0;
    presetn <= 1'b0;
    apb_req <= '0;
    ten_key_input <= 10'h0;
    {key_a, key_b, press_a, press_b} <= '0;
    hexv = 32'h0;
    tenv = 32'h0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    check("busy after reset", 32'h1, 32'(hex_scan_busy_flag));
    prev = 4'h0;
    for (int i = 0; i < 12 * DIV; i++)
    begin
      @(posedge pclk);
      if (prev != 4'h0 && matrix_drive_word[3:0] != prev)
        check("drive order", {28'h0, prev[2:0], prev[3]}, 32'(matrix_drive_word[3:0]));
      check("drive one hot", 32'h1, 32'($onehot(matrix_drive_word[3:0])));
      prev = matrix_drive_word[3:0];
    end
    rdchk("ctrl reset", ksi_pkg::OFF_CTRL, 32'h3);
    rdchk("mask reset", ksi_pkg::OFF_IRQ_MASK, 32'h0);
    rdchk("base reset", ksi_pkg::OFF_BASE, 32'h0);
    rdchk("flags reset", ksi_pkg::OFF_FLAGS, 32'h1);
    for (int k = 0; k < 16; k++)
      hex_key(4'(k));
    // Second key closed while the first is held must be ignored
    key_a <= 4'h5;
    press_a <= 1'b1;
    wait_held(1'b1);
    hexv = {hexv[27:0], 4'h5};
    key_b <= 4'h9;
    press_b <= 1'b1;
    repeat (20 * DIV) @(posedge pclk);
    rdchk("hex lockout keys", ksi_pkg::OFF_HEX_KEYS, 32'h20);
    rdchk("hex lockout low", ksi_pkg::OFF_HEX_LO, {16'h0, hexv[15:0]});
    press_a <= 1'b0;
    press_b <= 1'b0;
    wait_held(1'b0);
    apb(1'b1, ksi_pkg::OFF_CTRL, 32'h2);
    key_a <= 4'h3;
    press_a <= 1'b1;
    repeat (20 * DIV) @(posedge pclk);
    check("busy disabled", 32'h0, 32'(hex_scan_busy_flag));
    check("drive disabled", 32'h0, 32'(matrix_drive_word));
    rdchk("hex low disabled", ksi_pkg::OFF_HEX_LO, {16'h0, hexv[15:0]});
    press_a <= 1'b0;
    apb(1'b1, ksi_pkg::OFF_CTRL, 32'h3);
    for (int k = 0; k < 10; k++)
      ten_key(k);
    ten_key_input <= 10'h008;
    wait_ten(32'h8, 1'b1);
    tenv = {tenv[27:0], 4'h3};
    ten_key_input <= 10'h088;
    repeat (20 * DIV) @(posedge pclk);
    rdchk("ten lockout keys", ksi_pkg::OFF_TEN_KEYS, 32'h8);
    rdchk("ten lockout low", ksi_pkg::OFF_TEN_LO, {16'h0, tenv[15:0]});
    ten_key_input <= 10'h0;
    wait_ten(32'h3ff, 1'b0);
    check("irq masked", 32'h0, 32'(irq));
    apb(1'b1, ksi_pkg::OFF_IRQ_MASK, 32'h1);
    repeat (2) @(posedge pclk);
    check("irq unmasked", 32'h1, 32'(irq));
    rdchk("irq status", ksi_pkg::OFF_IRQ_STAT, 32'h3);
    apb(1'b1, ksi_pkg::OFF_IRQ_STAT, 32'h7);
    rdchk("irq cleared", ksi_pkg::OFF_IRQ_STAT, 32'h0);
    check("irq low", 32'h0, 32'(irq));
    apb(1'b0, 8'h2c, 32'h0);
    check("unmapped error", 32'h1, 32'(err));
    check("unmapped data", 32'h0, rd);
    for (int i = 0; i < 5; i++)
    begin
      logic [31:0] bases [5];
      logic [1:0]  flags [5];
      bases = '{32'h0000_0098, 32'h0000_0099, 32'h0000_000a, 32'h0099_0000, 32'h0100_0000};
      // Bit 1 error, bit 0 busy: the hex scanner stops while its own pointer is bad
      flags = '{2'h1, 2'h2, 2'h2, 2'h1, 2'h3};
      apb(1'b1, ksi_pkg::OFF_BASE, bases[i]);
      repeat (4) @(posedge pclk);
      check("error flag", 32'(flags[i][1]), 32'(error_flag));
      rdchk("flags error", ksi_pkg::OFF_FLAGS, {30'h0, flags[i]});
    end
    ten_key_input <= 10'h010;
    repeat (20 * DIV) @(posedge pclk);
    rdchk("ten low in error", ksi_pkg::OFF_TEN_LO, {16'h0, tenv[15:0]});
    ten_key_input <= 10'h0;
    rdchk("error event", ksi_pkg::OFF_IRQ_STAT, 32'h4);
    // Restart in mid-run: scanning must resume at once
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    check("busy after restart", 32'h1, 32'(hex_scan_busy_flag));
    check("error after restart", 32'h0, 32'(error_flag));
    final_report();
  end
endmodule : ksi_keypad_tb
`default_nettype wire
